// ### src/fcs_pkg.sv
// Shared constants and types of the Flash checksum scanner.
package fcs_pkg;

  // Register indexes; the bus byte address is four times the index.
  localparam logic [1:0] FCS_IDX_MAIN = 2'h0;
  localparam logic [1:0] FCS_IDX_SECT = 2'h1;
  localparam logic [1:0] FCS_IDX_STAT = 2'h2;
  localparam int unsigned FCS_AXI_AW  = 12;

  // Field positions.
  localparam int unsigned FCS_MAIN_RST_BIT  = 7;
  localparam int unsigned FCS_MAIN_ARM_BIT  = 1;
  localparam int unsigned FCS_MAIN_EN_BIT   = 0;
  localparam int unsigned FCS_STAT_OK_BIT   = 1;
  localparam int unsigned FCS_STAT_BUSY_BIT = 0;

  // Reset values.
  localparam logic [7:0] FCS_MAIN_RST = 8'h00;
  localparam logic [7:0] FCS_SECT_RST = 8'h00;
  localparam logic [7:0] FCS_STAT_RST = 8'h02;

  // Section selector codes.
  localparam logic [1:0] FCS_SECT_FLASH    = 2'h0;
  localparam logic [1:0] FCS_SECT_BOOT_APP = 2'h1;
  localparam logic [1:0] FCS_SECT_BOOT     = 2'h2;

  // Checksum engine.
  localparam logic [15:0] FCS_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] FCS_CRC_POLY = 16'h1021;
  localparam logic [15:0] FCS_CRC_GOOD = 16'h0000;

  // Timing in clock cycles.
  localparam logic [1:0] FCS_START_CYC = 2'h3;
  localparam logic [1:0] FCS_FETCH_CYC = 2'h3;

  // Bus answers.
  localparam logic [1:0] FCS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] FCS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FCS_IDLE,
    FCS_WAIT,
    FCS_SCAN,
    FCS_CHECK
  } fcs_state_t;

endpackage

// ### src/fcs_crc_byte.sv
// One byte step of the CCITT checksum shift register.
`timescale 1ns/1ps
module fcs_crc_byte
  import fcs_pkg::*;
(
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  output logic      [15:0] crc_out
);

  always_comb begin
    logic [15:0] c;
    c = crc_in;
    for (int i = 7; i >= 0; i--) begin
      // Bits enter most significant first.
      if (c[15] ^ data_in[i]) begin
        c = {c[14:0], 1'b0} ^ FCS_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc_out = c;
  end

endmodule // fcs_crc_byte

// ### src/fcs_flash_fetch.sv
// Flash word fetcher: one 16-bit word every three cycles.
`timescale 1ns/1ps
module fcs_flash_fetch
  import fcs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic [15:0] first_addr,
  input  wire logic [15:0] last_addr,
  output logic      [15:0] flash_addr,
  output logic             flash_rd,
  input  wire logic [15:0] flash_rdata,
  output logic             word_valid,
  output logic      [15:0] word,
  output logic             word_last
);

  typedef struct packed {
    logic        run;
    logic [1:0]  cnt;
    logic [15:0] addr;
    logic [15:0] last;
    logic        w_v;
    logic [15:0] w;
    logic        w_last;
  } fcs_fetch_t;

  fcs_fetch_t s_q;
  fcs_fetch_t s_d;

  always_comb begin
    s_d = s_q;
    if (ce) begin
      s_d.w_v = 1'b0;
      if (abort) begin
        s_d.run = 1'b0;
      end else if (start) begin
        s_d.run  = 1'b1;
        s_d.cnt  = 2'h0;
        s_d.addr = first_addr;
        s_d.last = last_addr;
      end else if (s_q.run) begin
        if (s_q.cnt == FCS_FETCH_CYC - 2'h1) begin
          s_d.w_v    = 1'b1;
          s_d.w      = flash_rdata;
          s_d.w_last = (s_q.addr == s_q.last);
          s_d.cnt    = 2'h0;
          if (s_q.addr == s_q.last) begin
            s_d.run = 1'b0;
          end else begin
            s_d.addr = s_q.addr + 16'h0002;
          end
        end else begin
          s_d.cnt = s_q.cnt + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flash_addr = s_q.addr;
  assign flash_rd   = ce && s_q.run && (s_q.cnt == 2'h0);
  assign word_valid = s_q.w_v;
  assign word       = s_q.w;
  assign word_last  = s_q.w_last;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  a_fetch_pace: assert property (flash_rd |=> !flash_rd ##1 !flash_rd)
    else $error("flash fetch issued faster than three cycles");

endmodule // fcs_flash_fetch

// ### src/fcs_scan_ctrl.sv
// Flash checksum scanner: registers, bus slave and scan sequencing.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module fcs_scan_ctrl
  import fcs_pkg::*;
#(
  parameter logic [15:0] FLASH_END = 16'h7FFF
)
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic [FCS_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic      [1:0]            s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [FCS_AXI_AW-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic      [31:0]           s_axi_rdata,
  output logic      [1:0]            s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  boot_scan_en,
  input  wire logic [1:0]            boot_section,
  input  wire logic [15:0]           boot_end,
  input  wire logic [15:0]           app_end,
  output logic      [15:0]           flash_addr,
  output logic                       flash_rd,
  input  wire logic [15:0]           flash_rdata,
  output logic                       cpu_stall,
  output logic                       nmi_req
);

  typedef struct packed {
    logic       aw_v;
    logic [1:0] aw_i;
    logic       aw_map;
    logic       w_v;
    logic [7:0] w_d;
    logic       w_s;
    logic       b_v;
    logic [1:0] b_r;
    logic       r_v;
    logic [7:0] r_d;
    logic [1:0] r_r;
    logic       en;
    logic       arm;
    logic [1:0] sect;
    logic       ok;
    logic       busy;
    logic       nmi;
    logic       boot_pend;
    logic       boot_run;
    logic       hang;
    fcs_state_t st;
    logic [1:0] dly;
    logic [15:0] crc;
  } fcs_regs_t;

  fcs_regs_t s_q;
  fcs_regs_t s_d;

  logic        wr_go;
  logic        wr_main;
  logic        main_ok;
  logic        rst_go;
  logic        arm_go;
  logic        start_go;
  logic        sect_go;
  logic        chk_pass;
  logic        chk_fail;
  logic        fetch_start;
  logic [15:0] end_addr;
  logic        word_valid;
  logic [15:0] word;
  logic        word_last;
  logic [15:0] crc_chain [0:2];

  ////////////////////////////////////////////////////////////////////////////
  // Write decode.

  assign wr_go   = s_q.aw_v && s_q.w_v && !s_q.b_v;
  assign wr_main = wr_go && s_q.aw_map && s_q.w_s &&
                   (s_q.aw_i == FCS_IDX_MAIN);
  assign main_ok = ce && wr_main && !s_q.nmi;
  // The strobe wins over the other bits of the same write.
  assign rst_go  = main_ok && s_q.w_d[FCS_MAIN_RST_BIT] &&
                   (!s_q.arm || !s_q.busy);
  assign arm_go  = main_ok && !rst_go && s_q.w_d[FCS_MAIN_ARM_BIT] &&
                   !s_q.busy;
  assign start_go = main_ok && !rst_go &&
                    s_q.w_d[FCS_MAIN_EN_BIT];
  assign sect_go = ce && wr_go && s_q.aw_map && s_q.w_s &&
                   (s_q.aw_i == FCS_IDX_SECT) &&
                   !s_q.busy && !s_q.nmi;

  assign chk_pass = ce && (s_q.st == FCS_CHECK) &&
                    (s_q.crc == FCS_CRC_GOOD);
  assign chk_fail = ce && (s_q.st == FCS_CHECK) &&
                    (s_q.crc != FCS_CRC_GOOD);

  // Reserved code 3 scans the whole Flash rather than nothing.
  always_comb begin
    case (s_q.sect)
      FCS_SECT_BOOT_APP: end_addr = app_end;
      FCS_SECT_BOOT:     end_addr = boot_end;
      default:           end_addr = FLASH_END;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    s_d = s_q;
    fetch_start = 1'b0;
    if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_d.aw_v   = 1'b1;
        s_d.aw_i   = s_axi_awaddr[3:2];
        s_d.aw_map = (s_axi_awaddr[FCS_AXI_AW-1:4] == '0) &&
                     (s_axi_awaddr[3:2] != 2'h3);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_d.w_v = 1'b1;
        s_d.w_d = s_axi_wdata[7:0];
        s_d.w_s = s_axi_wstrb[0];
      end
      if (wr_go) begin
        s_d.aw_v = 1'b0;
        s_d.w_v  = 1'b0;
        s_d.b_v  = 1'b1;
        s_d.b_r  = s_q.aw_map ? FCS_RESP_OKAY : FCS_RESP_SLVERR;
      end
      if (s_q.b_v && s_axi_bready) begin
        s_d.b_v = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_d.r_v = 1'b1;
        s_d.r_r = FCS_RESP_OKAY;
        case (s_axi_araddr[3:2])
          FCS_IDX_MAIN: s_d.r_d = {6'h00, s_q.arm, s_q.en};
          FCS_IDX_SECT: s_d.r_d = {6'h00, s_q.sect};
          FCS_IDX_STAT: s_d.r_d = {6'h00, s_q.ok, s_q.busy};
          default: begin
            s_d.r_d = 8'h00;
            s_d.r_r = FCS_RESP_SLVERR;
          end
        endcase
        if (s_axi_araddr[FCS_AXI_AW-1:4] != '0) begin
          s_d.r_d = 8'h00;
          s_d.r_r = FCS_RESP_SLVERR;
        end
      end
      if (s_q.r_v && s_axi_rready) begin
        s_d.r_v = 1'b0;
      end

      case (s_q.st)
        FCS_WAIT: begin
          // The CPU runs on through the start delay unless a start-up scan holds it.
          if (s_q.dly == FCS_START_CYC - 2'h1) begin
            s_d.st      = FCS_SCAN;
            fetch_start = 1'b1;
          end else begin
            s_d.dly = s_q.dly + 2'h1;
          end
        end
        FCS_SCAN: begin
          if (word_valid) begin
            s_d.crc = crc_chain[2];
            if (word_last) begin
              s_d.st = FCS_CHECK;
            end
          end
        end
        FCS_CHECK: begin
          s_d.busy     = 1'b0;
          s_d.ok       = chk_pass;
          s_d.st       = FCS_IDLE;
          s_d.boot_run = 1'b0;
          if (chk_fail && s_q.arm) begin
            s_d.nmi = 1'b1;
          end
          if (chk_fail && s_q.boot_run) begin
            s_d.hang = 1'b1;
          end
        end
        default: begin
          s_d.st = FCS_IDLE;
        end
      endcase

      if (arm_go) begin
        s_d.arm = 1'b1;
      end
      if (sect_go) begin
        s_d.sect = s_q.w_d[1:0];
      end
      if (start_go) begin
        s_d.en   = 1'b1;
        s_d.busy = 1'b1;
        s_d.st   = FCS_WAIT;
        s_d.dly  = 2'h0;
        s_d.crc  = FCS_CRC_INIT;
      end
      if (rst_go) begin
        // The arm bit and a raised NMI survive the strobe.
        s_d.en       = FCS_MAIN_RST[FCS_MAIN_EN_BIT];
        s_d.sect     = FCS_SECT_RST[1:0];
        s_d.ok       = FCS_STAT_RST[FCS_STAT_OK_BIT];
        s_d.busy     = FCS_STAT_RST[FCS_STAT_BUSY_BIT];
        s_d.st       = FCS_IDLE;
        s_d.boot_run = 1'b0;
      end
      // The strap is caught in the first enabled cycle after reset.
      if (s_q.boot_pend) begin
        s_d.boot_pend = 1'b0;
        if (boot_scan_en) begin
          s_d.en       = 1'b1;
          s_d.sect     = boot_section;
          s_d.busy     = 1'b1;
          s_d.st       = FCS_WAIT;
          s_d.dly      = 2'h0;
          s_d.crc      = FCS_CRC_INIT;
          s_d.boot_run = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q           <= '0;
      s_q.ok        <= FCS_STAT_RST[FCS_STAT_OK_BIT];
      s_q.boot_pend <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath.

  assign crc_chain[0] = s_q.crc;

  // Byte 0 of a word sits in the low lane and goes first.
  for (genvar g = 0; g < 2; g++) begin : g_byte
    fcs_crc_byte u_step (
      .crc_in  (crc_chain[g]),
      .data_in (word[8*g +: 8]),
      .crc_out (crc_chain[g+1])
    );
  end

  fcs_flash_fetch u_fetch (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ce          (ce),
    .start       (fetch_start),
    .abort       (rst_go || start_go),
    .first_addr  (16'h0000),
    .last_addr   ({end_addr[15:1], 1'b0}),
    .flash_addr  (flash_addr),
    .flash_rd    (flash_rd),
    .flash_rdata (flash_rdata),
    .word_valid  (word_valid),
    .word        (word),
    .word_last   (word_last)
  );

  assign s_axi_awready = ce && !s_q.aw_v;
  assign s_axi_wready  = ce && !s_q.w_v;
  assign s_axi_bvalid  = s_q.b_v;
  assign s_axi_bresp   = s_q.b_r;
  assign s_axi_arready = ce && !s_q.r_v;
  assign s_axi_rvalid  = s_q.r_v;
  assign s_axi_rresp   = s_q.r_r;
  assign s_axi_rdata   = {24'h00_0000, s_q.r_d};
  // A failed start-up scan keeps the CPU held for good.
  assign cpu_stall = (s_q.st == FCS_SCAN) || s_q.boot_run || s_q.hang;
  assign nmi_req   = s_q.nmi;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  a_rst_clears: assert property (rst_go |=>
      !s_q.en && !s_q.busy && s_q.sect == 2'h0 && s_q.ok)
    else $error("reset strobe did not clear the scanner");
  a_rst_locked: assert property (
      (wr_main && s_q.w_d[7] && s_q.arm && s_q.busy && !s_q.nmi &&
       s_q.st != FCS_CHECK) |=> s_q.busy)
    else $error("reset strobe acted while armed and busy");
  a_arm_keeps: assert property (
      rst_go |=> s_q.arm == $past(s_q.arm))
    else $error("reset strobe changed nmi_arm");
  a_arm_blocked: assert property (
      (s_q.busy && !s_q.arm) |=> !s_q.arm)
    else $error("nmi_arm set while busy");
  a_start_delay: assert property (
      (start_go && !s_q.boot_run && !s_q.hang) |=> (!cpu_stall)[*3])
    else $error("CPU stalled inside the start delay");
  a_scan_stalls: assert property (
      (start_go && !s_q.boot_run ##1 (!rst_go && !start_go)[*3])
      |=> cpu_stall)
    else $error("scan did not begin three cycles after enable");
  a_fail_flags: assert property (
      (chk_fail && !start_go && !rst_go) |=> !s_q.ok && !s_q.busy)
    else $error("failed check left passed flag or busy set");
  a_nmi_hold: assert property (nmi_req |=> nmi_req)
    else $error("NMI request dropped before system reset");
  a_fail_nmi: assert property (
      (chk_fail && s_q.arm) |=> nmi_req)
    else $error("armed failure raised no NMI");
  a_main_frozen: assert property (
      s_q.nmi |=> $stable(s_q.en) && $stable(s_q.arm))
    else $error("control register changed after NMI");
  a_sect_held: assert property (
      (s_q.busy && !rst_go && !s_q.boot_pend) |=> $stable(s_q.sect))
    else $error("section select changed while busy");
  a_pass_ok: assert property (
      (chk_pass && !start_go) |=> s_q.ok && !s_q.busy)
    else $error("passing check did not report success");

  c_pass:  cover property (chk_pass);
  c_fail:  cover property (chk_fail);
  c_nmi:   cover property ($rose(nmi_req));
  c_reset: cover property (rst_go && s_q.busy);

endmodule // fcs_scan_ctrl

// ### bench/fcs_flash_model.sv
// Behavioural model of the on-chip Flash that the scanner reads.
`timescale 1ns/1ps
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter int BOOT_END = 15
)
(
  input  wire logic        aclk,
  input  wire logic [15:0] flash_addr,
  input  wire logic        flash_rd,
  output logic      [15:0] flash_rdata
);
  logic [7:0]  mem [0:63];
  logic [15:0] addr_q = 16'h0000;
  logic        rd1_q  = 1'b0;
  logic        rd2_q  = 1'b0;
  logic [15:0] last_q = 16'h5a5a;
  logic [15:0] crc;

  function automatic logic [15:0] step(logic [15:0] c, logic [7:0] b);
    logic fb;
    for (int k = 0; k < 8; k++) begin
      fb = c[15] ^ b[7-k];
      c  = {c[14:0], 1'b0} ^ (fb ? FCS_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // Only the boot section carries a valid checksum; the others must fail.
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'(i * 37 + 5);
    end
    crc = FCS_CRC_INIT;
    for (int i = 0; i < BOOT_END - 1; i++) begin
      crc = step(crc, mem[i]);
    end
    mem[BOOT_END-1] = crc[15:8];
    mem[BOOT_END]   = crc[7:0];
  end

  always @(posedge aclk) begin
    rd1_q  <= flash_rd;
    rd2_q  <= rd1_q;
    last_q <= flash_rdata;
    if (flash_rd) begin
      addr_q <= flash_addr;
    end
  end

  // Outside the fetch window the data lines toggle so stale data never passes.
  assign flash_rdata = (rd1_q || rd2_q) ?
    {mem[addr_q[5:0] | 6'h01], mem[addr_q[5:0] & 6'h3e]} : ~last_q;
endmodule // fcs_flash_model

// ### bench/testbench.sv
// Register-level testbench of the Flash checksum scanner.
`timescale 1ns/1ps
module testbench;
  import fcs_pkg::*;
  localparam logic [11:0] A_MAIN = {8'h00, FCS_IDX_MAIN, 2'b00};
  localparam logic [11:0] A_SECT = {8'h00, FCS_IDX_SECT, 2'b00};
  localparam logic [11:0] A_STAT = {8'h00, FCS_IDX_STAT, 2'b00};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp, boot_section = 2'h0;
  logic        boot_scan_en = 1'b0;
  logic [15:0] flash_addr, flash_rdata;
  logic        flash_rd, cpu_stall, nmi_req;
  logic [7:0]  v;
  logic [1:0]  rs;
  int          n_errors = 0;
  int          num_checks = 0;

  always #2 aclk = ~aclk;

  fcs_scan_ctrl #(.FLASH_END(16'h003F)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .boot_scan_en(boot_scan_en), .boot_section(boot_section),
    .boot_end(16'h000F), .app_end(16'h001F), .flash_addr(flash_addr),
    .flash_rd(flash_rd), .flash_rdata(flash_rdata), .cpu_stall(cpu_stall),
    .nmi_req(nmi_req));

  fcs_flash_model #(.BOOT_END(15)) flash_u (
    .aclk(aclk), .flash_addr(flash_addr), .flash_rd(flash_rd),
    .flash_rdata(flash_rdata));

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic hang();
    n_errors++;
    print_verdict();
  endtask

  // Handshakes are judged at the falling edge, so the value seen is the one
  // the rising edge that follows will take.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    logic aw_ok, w_ok, b_ok;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'h1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    b_ok = 1'b0;
    while (!b_ok && n < 50) begin
      @(negedge aclk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid && bready;
      if (b_ok) chk(bresp, FCS_RESP_OKAY);
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!b_ok) hang();
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d,
                    output logic [1:0] r);
    int n;
    logic ar_ok, r_ok;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    r_ok = 1'b0;
    while (!r_ok && n < 50) begin
      @(negedge aclk);
      ar_ok = arvalid && arready;
      r_ok = rvalid && rready;
      d = rdata[7:0];
      r = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!r_ok) hang();
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    rd(a, v, rs);
    chk(v, e);
  endtask

  // Software trusts the passed flag only once busy reads zero.
  task automatic wait_idle();
    int n;
    n = 0;
    v = 8'h01;
    while (v[0] !== 1'b0 && n < 400) begin
      rd(A_STAT, v, rs);
      n++;
    end
    if (v[0] !== 1'b0) hang();
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    rchk(A_MAIN, FCS_MAIN_RST);
    rchk(A_SECT, FCS_SECT_RST);
    rchk(A_STAT, 8'h02);
    rd(12'h00C, v, rs);
    chk(rs, FCS_RESP_SLVERR);
    chk(v, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(A_SECT, 8'(i));
      rchk(A_SECT, 8'(i));
      wr(A_MAIN, 8'h01);
      chk(cpu_stall, 1'b0);
      if (i == 2) begin
        // A low enable must stretch the start delay; no scan may begin.
        ce <= 1'b0;
        repeat (6) begin
          @(posedge aclk);
          chk(cpu_stall, 1'b0);
        end
        ce <= 1'b1;
      end
      rd(A_STAT, v, rs);
      chk(v[0], 1'b1);
      if (i == 0) begin
        wr(A_SECT, 8'h03);
        wr(A_MAIN, 8'h00);
        wr(A_MAIN, 8'h02);
        chk(cpu_stall, 1'b1);
        rchk(A_SECT, 8'h00);
        rchk(A_MAIN, 8'h01);
        rd(A_STAT, v, rs);
        chk(v[0], 1'b1);
      end
      wait_idle();
      chk(cpu_stall, 1'b0);
      rchk(A_STAT, (i == 2) ? 8'h02 : 8'h00);
      rchk(A_MAIN, 8'h01);
    end
    chk(nmi_req, 1'b0);
    wr(A_SECT, 8'h03);
    rchk(A_SECT, 8'h03);
    wr(A_SECT, 8'h02);
    wr(A_MAIN, 8'h01);
    wr(A_MAIN, 8'h80);
    chk(cpu_stall, 1'b0);
    rchk(A_MAIN, 8'h00);
    rchk(A_SECT, 8'h00);
    rchk(A_STAT, 8'h02);
    wr(A_MAIN, 8'h02);
    rchk(A_MAIN, 8'h02);
    wr(A_MAIN, 8'h80);
    rchk(A_MAIN, 8'h02);
    wr(A_SECT, 8'h02);
    wr(A_MAIN, 8'h03);
    wr(A_MAIN, 8'h80);
    rd(A_STAT, v, rs);
    chk(v[0], 1'b1);
    wait_idle();
    rchk(A_STAT, 8'h02);
    chk(nmi_req, 1'b0);
    wr(A_SECT, 8'h01);
    wr(A_MAIN, 8'h03);
    wait_idle();
    rchk(A_STAT, 8'h00);
    chk(nmi_req, 1'b1);
    wr(A_MAIN, 8'h80);
    rchk(A_MAIN, 8'h03);
    wr(A_SECT, 8'h02);
    rchk(A_SECT, 8'h01);
    repeat (20) @(posedge aclk);
    chk(nmi_req, 1'b1);
    boot_scan_en <= 1'b1;
    boot_section <= 2'h2;
    do_reset();
    rchk(A_MAIN, 8'h01);
    rchk(A_SECT, 8'h02);
    chk(nmi_req, 1'b0);
    wait_idle();
    rchk(A_STAT, 8'h02);
    chk(cpu_stall, 1'b0);
    print_verdict();
  end
endmodule // testbench
